/* design/pp_options_slip.sv */
// positioning option word, setpoint handshake, rotary target resolution,
// following error, position-loop correction and slippage monitor
// assumes inputs synchronous to clock; object access via the od_* port
`timescale 1ns/1ns
`include "pp_options_map.svh"

module pp_options_slip #(
   parameter int unsigned SLIP_TICK_CYCLES = `SLIP_TICK_CYCLES
) (
   input wire logic clock,
   input wire logic resetn,
   input wire logic ce,
   // object-dictionary access
   input wire logic od_read,
   input wire logic od_write,
   input wire logic [15:0] od_index,
   input wire logic [31:0] od_wdata,
   output logic [31:0] od_rdata,
   output logic od_ack,
   output logic od_error,
   // controlword writes from the fieldbus master
   input wire logic cw_write,
   input wire logic [15:0] cw_data,
   // drive state
   input wire logic pp_mode,
   input wire logic pv_mode,
   input wire logic target_reached,
   input wire logic signed [31:0] target_position,
   input wire logic signed [31:0] ramp_output,
   input wire logic signed [31:0] actual_position,
   input wire logic signed [31:0] demand_position,
   input wire logic signed [31:0] range_min,
   input wire logic signed [31:0] range_max,
   input wire logic signed [15:0] loop_kp,
   input wire logic signed [15:0] loop_ki,
   input wire logic signed [31:0] actual_speed,
   input wire logic signed [31:0] set_speed,
   input wire logic [31:0] slip_time_ms,
   input wire logic slip_reaction_set,
   // results
   output logic new_setpoint,
   output logic setpoint_ack,
   output logic slippage,
   output logic slip_log_entry,
   output logic signed [31:0] internal_target,
   output logic move_positive,
   output logic target_valid
);
   import pp_options_pkg::*;

   typedef struct packed {
      logic [15:0] option_word;
      logic [31:0] slip_limit;
      logic signed [31:0] follow_err;
      logic signed [31:0] integ;
      logic signed [31:0] correction;
      logic signed [31:0] prev_target;
      logic has_target;
      logic signed [31:0] target;
      logic move_pos;
      logic new_sp;
      logic relative;
      logic ack;
      handshake_t hs;
      logic [31:0] rdata;
      logic od_ack;
      logic od_err;
      logic slip_prev;
      logic slip_log;
   } top_state_t;

   top_state_t s;
   top_state_t n;
   logic slip_run;
   logic slip_expired;
   rel_ref_t rel_sel;
   release_t rel_mode;
   direction_t dir_sel;
   logic [32:0] abs_dev;
   logic [32:0] abs_lim;
   logic signed [32:0] speed_dev;
   logic signed [32:0] base_sum;
   logic signed [31:0] base;
   logic signed [31:0] goal;
   logic signed [31:0] span;
   logic signed [31:0] diff;
   logic signed [47:0] p_term;
   logic signed [47:0] i_term;

   // reserved codes fall back to 00 so a bad write stays predictable
   always_comb begin
      rel_sel = rel_ref_t'(s.option_word[`POS_REL_REF +: 2]);
      if (rel_sel == REL_RESERVED) rel_sel = REL_PREV_TARGET;
      rel_mode = release_t'(s.option_word[`POS_RELEASE +: 2]);
      if (rel_mode == RELEASE_RESERVED) rel_mode = RELEASE_HOST;
      dir_sel = direction_t'(s.option_word[`POS_DIRECTION +: 2]);
   end

   // band check is symmetric: only the magnitude of the deviation counts
   always_comb begin
      speed_dev = 33'(actual_speed) - 33'(set_speed);
      abs_dev = speed_dev[32] ? 33'(-speed_dev) : 33'(speed_dev);
      abs_lim = s.slip_limit[31] ? 33'(-$signed({s.slip_limit[31], s.slip_limit})) : {1'b0, s.slip_limit};
      slip_run = pv_mode && (s.slip_limit != `SLIP_OFF_VALUE) && (abs_dev > abs_lim);
   end

   // base for a new target, then wrap and direction policy
   always_comb begin
      base = 32'sd0;
      if (s.relative) begin
         unique case (rel_sel)
            REL_PREV_TARGET: base = s.has_target ? s.prev_target : 32'sd0;
            REL_RAMP: base = ramp_output;
            REL_ACTUAL: base = actual_position;
            default: base = 32'sd0;
         endcase
      end
      base_sum = 33'(base) + 33'(target_position);
      goal = base_sum[31:0];
      span = range_max - range_min;
      // only the linear policy is folded back into the range; the other three policies keep the raw sum
      if (dir_sel == DIR_LINEAR) begin
         if (goal >= range_max) begin
            goal = range_min + (goal - range_max);
         end else if (goal < range_min) begin
            goal = range_max - (range_min - goal);
         end
      end
      diff = goal - actual_position;
      if (diff < 32'sd0) begin
         diff = diff + span;
      end
   end

   // PI products; truncation to 32 bits is deliberate, gains are Q8
   assign p_term = 48'(s.follow_err) * 48'(loop_kp);
   assign i_term = 48'(s.integ) * 48'(loop_ki);

   always_comb begin
      n = s;
      n.od_ack = 1'b0;
      n.od_err = 1'b0;
      n.slip_log = 1'b0;

      // object reads and writes, answered one cycle later
      if (od_write) begin
         n.od_ack = 1'b1;
         if (od_index == `IDX_OPTION_WORD) begin
            n.option_word = od_wdata[15:0];
         end else if (od_index == `IDX_SLIP_LIMIT) begin
            n.slip_limit = od_wdata;
         end else begin
            n.od_err = 1'b1; // read-only or unknown object
         end
      end else if (od_read) begin
         n.od_ack = 1'b1;
         n.rdata = 32'h00000000;
         if (od_index == `IDX_OPTION_WORD) begin
            n.rdata = {16'h0000, s.option_word};
         end else if (od_index == `IDX_FOLLOW_ERR) begin
            n.rdata = s.follow_err;
         end else if (od_index == `IDX_SLIP_LIMIT) begin
            n.rdata = s.slip_limit;
         end else if (od_index == `IDX_CORRECTION) begin
            n.rdata = s.correction;
         end else begin
            n.od_err = 1'b1;
         end
      end

      // position loop: error, integral and correction speed
      n.follow_err = demand_position - actual_position;
      n.integ = s.integ + s.follow_err;
      n.correction = p_term[39:8] + i_term[39:8];

      // setpoint handshake
      unique case (s.hs)
         HS_IDLE: begin
            if (s.new_sp && pp_mode) begin
               n.ack = 1'b1;
               n.hs = HS_ACKED;
               n.target = goal;
               n.prev_target = goal;
               n.has_target = 1'b1;
               unique case (dir_sel)
                  DIR_LINEAR: n.move_pos = (goal >= actual_position);
                  DIR_NEGATIVE: n.move_pos = 1'b0;
                  DIR_POSITIVE: n.move_pos = 1'b1;
                  DIR_SHORTEST: n.move_pos = (diff < (span >>> 1));
               endcase
            end
         end
         HS_ACKED: begin
            if (!s.new_sp) begin
               n.ack = 1'b0;
               n.hs = HS_IDLE;
            end else if (rel_mode == RELEASE_ASAP) begin
               n.new_sp = 1'b0;
               n.hs = HS_RELEASED;
            end else if (rel_mode == RELEASE_ON_REACH && target_reached) begin
               n.new_sp = 1'b0;
               n.hs = HS_RELEASED;
            end
         end
         HS_RELEASED: begin
            n.ack = 1'b0; // acknowledge drops after the bit
            n.hs = HS_IDLE;
         end
      endcase

      // a host write in the same cycle wins over the device's own clear
      if (cw_write) begin
         n.new_sp = cw_data[`CW_NEW_SETPOINT];
         n.relative = cw_data[`CW_RELATIVE];
      end

      // log only on the first cycle of a slippage error
      n.slip_prev = slip_expired;
      n.slip_log = slip_expired && !s.slip_prev && slip_reaction_set;
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         s <= '0;
         s.option_word <= `RST_OPTION_WORD;
         s.slip_limit <= `RST_SLIP_LIMIT;
         s.hs <= HS_IDLE;
      end else if (ce) begin
         s <= n;
      end
   end

   // slippage must persist past the configured time before the flag rises
   deviation_timer #(
      .TICK_CYCLES(SLIP_TICK_CYCLES)
   ) slip_timer (
      .clock(clock),
      .resetn(resetn),
      .ce(ce),
      .run(slip_run),
      .limit_ticks(slip_time_ms),
      .expired(slip_expired)
   );

   // every output straight from a flop
   assign od_rdata = s.rdata;
   assign od_ack = s.od_ack;
   assign od_error = s.od_err;
   assign new_setpoint = s.new_sp;
   assign setpoint_ack = s.ack;
   assign slippage = slip_expired;
   assign slip_log_entry = s.slip_log;
   assign internal_target = s.target;
   assign move_positive = s.move_pos;
   assign target_valid = s.has_target;
endmodule

/* design/pp_options_map.svh */
// object indices, field positions, reset values and timing counts
// assumes the includer reads registers through the object-dictionary port
`ifndef PP_OPTIONS_MAP_SVH
`define PP_OPTIONS_MAP_SVH

// object indices as printed
`define IDX_OPTION_WORD 16'h60F2
`define IDX_FOLLOW_ERR 16'h60F4
`define IDX_SLIP_LIMIT 16'h60F8
`define IDX_CORRECTION 16'h60FA

// reset values and the slippage-off value
`define RST_OPTION_WORD 16'h0001
`define RST_SLIP_LIMIT 32'h00000190
`define SLIP_OFF_VALUE 32'h7FFFFFFF

// option word field positions (low bit of each field)
`define POS_REL_REF 0
`define POS_FURTHER 2
`define POS_RELEASE 4
`define POS_DIRECTION 6
`define POS_INTERP 8
`define POS_MAKER 15

// controlword and statusword bit numbers
`define CW_NEW_SETPOINT 4
`define CW_RELATIVE 6
`define SW_SETPOINT_ACK 12
`define SW_SLIPPAGE 13

// slippage time unit: one millisecond at a 10 ns clock
`define CLOCK_PERIOD_NS 10
`define SLIP_TICK_NS 1000000
`define SLIP_TICK_CYCLES (`SLIP_TICK_NS / `CLOCK_PERIOD_NS)

`endif

/* design/pp_options_pkg.sv */
// types shared by the positioning option and slippage logic
// assumes pp_options_map.svh supplies the numbers
package pp_options_pkg;
   typedef enum logic [1:0] {REL_PREV_TARGET, REL_RAMP, REL_ACTUAL, REL_RESERVED} rel_ref_t;
   typedef enum logic [1:0] {RELEASE_HOST, RELEASE_ON_REACH, RELEASE_ASAP, RELEASE_RESERVED} release_t;
   typedef enum logic [1:0] {DIR_LINEAR, DIR_NEGATIVE, DIR_POSITIVE, DIR_SHORTEST} direction_t;
   typedef enum logic [1:0] {HS_IDLE, HS_ACKED, HS_RELEASED} handshake_t;
endpackage

/* design/deviation_timer.sv */
// counts how long a condition has held, in ticks of a prescaler
// assumes the caller drops run whenever the condition ends
`timescale 1ns/1ns
module deviation_timer #(
   parameter int unsigned TICK_CYCLES = 100000
) (
   input wire logic clock,
   input wire logic resetn,
   input wire logic ce,
   input wire logic run,
   input wire logic [31:0] limit_ticks,
   output logic expired
);
   typedef struct packed {
      logic [31:0] prescale;
      logic [31:0] ticks;
      logic expired;
   } timer_state_t;

   timer_state_t s;
   timer_state_t n;

   // restart on every break so only an unbroken deviation counts
   always_comb begin
      n = s;
      if (!run) begin
         n.prescale = '0;
         n.ticks = '0;
         n.expired = 1'b0;
      end else if (s.prescale == 32'(TICK_CYCLES - 1)) begin
         n.prescale = '0;
         if (s.ticks != 32'hFFFFFFFF) begin
            n.ticks = s.ticks + 32'h1;
         end
      end else begin
         n.prescale = s.prescale + 32'h1;
      end
      // strictly longer than the configured time
      if (run && s.ticks > limit_ticks) begin
         n.expired = 1'b1;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         s <= '0;
      end else if (ce) begin
         s <= n;
      end
   end

   assign expired = s.expired;
endmodule

/* verif/pp_options_slip_sva.sv */
// checker for the option word, setpoint handshake and slippage ports
// assumes it is bound to pp_options_slip and sees only its ports
`timescale 1ns/1ns
module pp_options_slip_sva (
   input wire logic clock,
   input wire logic resetn,
   input wire logic ce,
   input wire logic od_read,
   input wire logic od_write,
   input wire logic [15:0] od_index,
   input wire logic od_ack,
   input wire logic od_error,
   input wire logic pv_mode,
   input wire logic slip_reaction_set,
   input wire logic new_setpoint,
   input wire logic setpoint_ack,
   input wire logic slippage,
   input wire logic slip_log_entry,
   input wire logic target_valid
);
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   // one taken access, and a slippage rise with a reaction set
   sequence s_req;
      ce && (od_read || od_write);
   endsequence
   sequence s_rise;
      ce && $rose(slippage) && slip_reaction_set;
   endsequence
   property p_ack;
      s_req |=> od_ack;
   endproperty
   property p_ro;
      ce && od_write && (od_index == 16'h60F4 || od_index == 16'h60FA) |=> od_ack && od_error;
   endproperty
   property p_ok;
      ce && !od_write && od_read && od_index == 16'h60F2 |=> !od_error;
   endproperty
   property p_hold;
      ce && setpoint_ack && new_setpoint |=> setpoint_ack;
   endproperty
   property p_drop;
      ce && setpoint_ack && !new_setpoint |=> !setpoint_ack;
   endproperty
   property p_accept;
      $rose(setpoint_ack) |-> $past(new_setpoint) && target_valid;
   endproperty
   property p_pv;
      ce && !pv_mode |=> !slippage;
   endproperty
   property p_log;
      s_rise |=> slip_log_entry;
   endproperty
   property p_log_cause;
      slip_log_entry |-> $past(slippage) && !$past(slippage, 2);
   endproperty
   a_ack: assert property (p_ack) else $error("access not answered");
   a_ro: assert property (p_ro) else $error("read-only write not refused");
   a_ok: assert property (p_ok) else $error("option word read flagged");
   a_hold: assert property (p_hold) else $error("acknowledge lost early");
   a_drop: assert property (p_drop) else $error("acknowledge kept after release");
   a_accept: assert property (p_accept) else $error("acknowledge without setpoint");
   a_pv: assert property (p_pv) else $error("slippage outside velocity mode");
   a_log: assert property (p_log) else $error("no history entry");
   a_log_cause: assert property (p_log_cause) else $error("stray history entry");
endmodule

bind pp_options_slip pp_options_slip_sva pp_options_slip_sva_i (.*);

/* verif/fieldbus_master.sv */
// fieldbus master model issuing controlword writes
// assumes go pulses one cycle from the bench
`timescale 1ns/1ns
module fieldbus_master (
   input wire logic clock,
   input wire logic go,
   input wire logic [15:0] word,
   output logic cw_write = 1'b0,
   output logic [15:0] cw_data = 16'h0000
);
   // host clears new setpoint itself by writing bit 4 low; data inverted when idle so stale words never look fresh
   always @(posedge clock) begin
      cw_write <= go;
      cw_data <= go ? word : ~cw_data;
   end
endmodule

/* verif/tb_pp_options_slip.sv */
// self-checking bench for the option word and slippage block
// assumes the fieldbus master model and the bound checker
`timescale 1ns/1ns
module tb_pp_options_slip;
   typedef struct {logic wr; logic [15:0] idx; logic [31:0] wd; logic [31:0] rd; logic err;} row_t;
   row_t rows[10];
   logic clock = 0, resetn = 0, ce = 1, od_read = 0, od_write = 0, go = 0, pp_mode = 1, pv_mode = 0;
   logic target_reached = 0, slip_reaction_set = 1, cw_write, new_setpoint, setpoint_ack, slippage;
   logic slip_log_entry, od_ack, od_error, move_positive, target_valid;
   logic [15:0] od_index = 0, word = 0, cw_data;
   logic [31:0] od_wdata = 0, od_rdata, slip_time_ms = 2;
   logic signed [31:0] target_position = 0, ramp_output = 50, actual_position = 180, demand_position = 190;
   logic signed [31:0] range_min = 0, range_max = 360, actual_speed = 2000, set_speed = 1000, internal_target;
   logic signed [15:0] loop_kp = 16'sh0100, loop_ki = 16'sh0000;
   int n_errors = 0, n_tests = 0, cyc = 0;
   initial forever #5 clock = ~clock;
   fieldbus_master fieldbus_master_i (.clock(clock), .go(go), .word(word), .cw_write(cw_write), .cw_data(cw_data));
   pp_options_slip #(.SLIP_TICK_CYCLES(4)) pp_options_slip_i (.*);
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task results;
      if (n_errors == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task acc(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
      @(posedge clock);
      od_write <= wr;
      od_read <= !wr;
      od_index <= idx;
      od_wdata <= wd;
      // strobes drop on the edge that takes them, so each call is one access
      @(posedge clock);
      od_write <= 0;
      od_read <= 0;
      #1;
      chk("od_ack", 1, od_ack);
   endtask
   task send(input logic [15:0] w, input logic [31:0] t);
      @(posedge clock);
      go <= 1;
      word <= w;
      target_position <= t;
      @(posedge clock);
      go <= 0;
   endtask
   task automatic wt(ref logic s, input logic want, input string n);
      for (int k = 0; k < 40 && s !== want; k++) tick(1);
      chk(n, want, s);
   endtask
   task mv(input logic [15:0] opt, input logic [15:0] cw, input logic [31:0] t, et, input logic ed);
      acc(1, 16'h60F2, opt);
      send(cw, t);
      wt(setpoint_ack, 1, "setpoint_ack");
      chk("internal_target", et, internal_target);
      chk("move_positive", ed, move_positive);
      wt(setpoint_ack, 0, "setpoint_ack");
      chk("new_setpoint", 0, new_setpoint);
   endtask
   // run-time ceiling against hangs
   always @(posedge clock) begin
      cyc++;
      if (cyc == 3000) begin
         n_errors++;
         results;
      end
   end
   initial begin
      rows = '{'{0, 16'h60F2, 0, 32'h1, 0},
         '{0, 16'h60F8, 0, 32'h190, 0},
         '{0, 16'h60F4, 0, 32'hA, 0},
         '{0, 16'h60FA, 0, 32'hA, 0},
         '{1, 16'h60F4, 1, 0, 1},
         '{1, 16'h60FA, 1, 0, 1},
         '{0, 16'h6000, 0, 0, 1},
         '{1, 16'h60F2, 32'h80E6, 0, 0},
         '{0, 16'h60F2, 0, 32'h80E6, 0},
         '{1, 16'h60F8, 32'h7FFFFFFF, 0, 0}};
      tick(3);
      @(posedge clock) resetn <= 1;
      foreach (rows[i]) begin
         acc(rows[i].wr, rows[i].idx, rows[i].wd);
         if (!rows[i].wr) chk("od_rdata", rows[i].rd, od_rdata);
         chk("od_error", rows[i].err, od_error);
      end
      mv(16'h0022, 16'h0050, 5, 185, 1);
      mv(16'h0020, 16'h0050, 7, 192, 1);
      mv(16'h0021, 16'h0050, 3, 53, 0);
      mv(16'h0023, 16'h0050, 1, 54, 0);
      mv(16'h0022, 16'h0010, 90, 90, 0);
      mv(16'h0060, 16'h0010, 200, 200, 0);
      mv(16'h00A0, 16'h0010, 90, 90, 1);
      mv(16'h00E0, 16'h0010, 90, 90, 0);
      mv(16'h00E0, 16'h0010, 200, 200, 1);
      mv(16'h0020, 16'h0010, 400, 40, 0);
      // host release: bit stays until the host clears it
      acc(1, 16'h60F2, 16'h0000);
      send(16'h0010, 100);
      wt(setpoint_ack, 1, "setpoint_ack");
      tick(6);
      chk("new_setpoint", 1, new_setpoint);
      send(16'h0000, 100);
      wt(setpoint_ack, 0, "setpoint_ack");
      // release on reach: held until target reached
      acc(1, 16'h60F2, 16'h0010);
      send(16'h0010, 120);
      tick(8);
      chk("new_setpoint", 1, new_setpoint);
      @(posedge clock) target_reached <= 1;
      wt(new_setpoint, 0, "new_setpoint");
      wt(setpoint_ack, 0, "setpoint_ack");
      @(posedge clock) pv_mode <= 1;
      tick(40);
      chk("slippage", 0, slippage);
      acc(1, 16'h60F8, 32'h190);
      @(posedge clock) actual_speed <= 1401;
      tick(8);
      chk("slippage", 0, slippage);
      wt(slippage, 1, "slippage");
      // history entry follows the first cycle of the flag
      tick(1);
      chk("slip_log_entry", 1, slip_log_entry);
      @(posedge clock) actual_speed <= 1000;
      tick(3);
      chk("slippage", 0, slippage);
      @(posedge clock) actual_speed <= 599;
      wt(slippage, 1, "slippage");
      @(posedge clock) actual_speed <= 1400;
      tick(40);
      chk("slippage", 0, slippage);
      results;
   end
endmodule
